// >>> shared/lcj_regs.vh
// register map, field positions, reset values and timing of the limit judge
`ifndef LCJ_REGS_VH
`define LCJ_REGS_VH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define LCJ_A_CTRL   8'h00
`define LCJ_A_STAT   8'h04
`define LCJ_A_LIM0   8'h08
`define LCJ_A_LIM7   8'h24
`define LCJ_A_RREL   8'h28
`define LCJ_A_VREL   8'h2C
`define LCJ_A_RSHOW  8'h30
`define LCJ_A_VSHOW  8'h34
// ---------------------------------------------
// control fields
// ---------------------------------------------
`define LCJ_C_EN     0
`define LCJ_C_EXT    1
`define LCJ_C_BLO    2
`define LCJ_C_BHI    4
`define LCJ_C_RTOL   5
`define LCJ_C_VTOL   6
`define LCJ_C_ARNG   7
`define LCJ_CTRL_RST 8'h00
`define LCJ_LIM_RST  32'h00000000
// ---------------------------------------------
// status fields
// ---------------------------------------------
`define LCJ_S_REJ    6
// ---------------------------------------------
// beeper settings
// ---------------------------------------------
`define LCJ_BP_OFF   3'h0
`define LCJ_BP_IN    3'h1
`define LCJ_BP_REJ   3'h2
`define LCJ_BP_BT1   3'h3
`define LCJ_BP_BT2   3'h4
// ---------------------------------------------
// value ranges, percent in 0.001 % steps
// ---------------------------------------------
`define LCJ_RES_MAX  32'h0001869F
`define LCJ_VOLT_MAX 32'h000F423F
`define LCJ_TOL_MAX  32'h0001869F
`define LCJ_FULL_PCT 64'h00000000000186A0
// ---------------------------------------------
// beeper timing
// ---------------------------------------------
`define LCJ_CLK_HZ   32'h05F5E100
`define LCJ_BEEP_MS  32'h00000064
`define LCJ_BEEP_CYC (`LCJ_BEEP_MS * (`LCJ_CLK_HZ / 32'h000003E8))
`define LCJ_ONCE_MS  32'h000000C8
`define LCJ_ONCE_CYC (`LCJ_ONCE_MS * (`LCJ_CLK_HZ / 32'h000003E8))
`endif

// >>> core/lcj_judge.v
// window judge of one quantity with tolerance limits and relative value
`timescale 1ns/1ns
`include "lcj_regs.vh"
module lcj_judge (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // limit set
  input  wire        use_tol,
  input  wire [31:0] upper_lim,
  input  wire [31:0] lower_lim,
  input  wire [31:0] nominal,
  input  wire [31:0] tol,
  // measurement
  input  wire        judge_go,
  input  wire        clr,
  input  wire        meas_ok,
  input  wire [31:0] meas_val,
  // verdict
  output reg         over_q,
  output reg         pass_q,
  output reg         under_q,
  output reg  [31:0] rel_q,
  output reg  [31:0] mag_q
);

  // ---------------------------------------------
  // limit derivation
  // ---------------------------------------------
  function [31:0] scale;
    input [63:0] n;
    input [63:0] f;
    reg   [63:0] p;
    begin
      p     = (n * f) / `LCJ_FULL_PCT;
      scale = p[31:0];
    end
  endfunction

  wire [63:0] nom_w = {32'h00000000, nominal};
  wire [63:0] tol_w = {32'h00000000, tol};
  wire [31:0] hi_w  = use_tol ? scale(nom_w, `LCJ_FULL_PCT + tol_w) : upper_lim;
  wire [31:0] lo_w  = use_tol ? scale(nom_w, `LCJ_FULL_PCT - tol_w) : lower_lim;
  wire [31:0] mag_w = meas_val[31] ? (~meas_val + 32'h00000001) : meas_val;

  // ---------------------------------------------
  // relative deviation, saturated at +-100 %
  // ---------------------------------------------
  wire        [63:0] full_w = `LCJ_FULL_PCT;
  wire signed [63:0] diff_w = $signed({{32{meas_val[31]}}, meas_val}) - $signed(nom_w);
  wire signed [63:0] num_w  = diff_w * $signed(`LCJ_FULL_PCT);
  wire signed [63:0] quo_w  = (nominal == 32'h00000000) ? 64'sh0 : num_w / $signed(nom_w);
  reg         [31:0] rel_w;

  always @* begin
    if (quo_w > $signed(`LCJ_FULL_PCT)) begin
      rel_w = full_w[31:0];
    end else if (quo_w < -$signed(`LCJ_FULL_PCT)) begin
      rel_w = 32'hFFFE7960;
    end else begin
      rel_w = quo_w[31:0];
    end
  end

  // ---------------------------------------------
  // verdict, exactly one or none
  // ---------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n || clr) begin
      over_q  <= 1'b0;
      pass_q  <= 1'b0;
      under_q <= 1'b0;
      rel_q   <= 32'h00000000;
      mag_q   <= 32'h00000000;
    end else if (judge_go) begin
      rel_q   <= rel_w;
      mag_q   <= mag_w;
      if (!meas_ok) begin
        over_q  <= 1'b0;
        pass_q  <= 1'b0;
        under_q <= 1'b0;
      end else if (mag_w > hi_w) begin
        over_q  <= 1'b1;
        pass_q  <= 1'b0;
        under_q <= 1'b0;
      end else if (mag_w < lo_w) begin
        over_q  <= 1'b0;
        pass_q  <= 1'b0;
        under_q <= 1'b1;
      end else begin
        over_q  <= 1'b0;
        pass_q  <= 1'b1;
        under_q <= 1'b0;
      end
    end
  end

endmodule

// >>> core/lcj_top.v
// limit comparator judge: register slave, two judges, beeper, outside port
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`include "lcj_regs.vh"
module lcj_top #(
  parameter [31:0] BEEP_TICKS = `LCJ_BEEP_CYC,
  parameter [31:0] ONCE_TICKS = `LCJ_ONCE_CYC
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // measurement front end
  input  wire        meas_valid,
  input  wire        res_ok,
  input  wire [31:0] res_val,
  input  wire        volt_ok,
  input  wire [31:0] volt_val,
  // outside control port
  input  wire        ext_judge_en,
  output reg         ext_over_q,
  output reg         ext_pass_q,
  output reg         ext_under_q,
  // indicators
  output wire        res_over_max_bound,
  output wire        res_pass,
  output wire        res_under_min_bound,
  output wire        volt_over_max_bound,
  output wire        volt_pass,
  output wire        volt_under_min_bound,
  // beeper and range control
  output reg         beep_q,
  output reg         autorange_en_q
);

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          merge[b*8 +: 8] = wd[b*8 +: 8];
        end
      end
    end
  endfunction

  function [31:0] lim_max;
    input [2:0] idx;
    begin
      if (idx[1:0] == 2'h3) begin
        lim_max = `LCJ_TOL_MAX;
      end else if (idx[2]) begin
        lim_max = `LCJ_VOLT_MAX;
      end else begin
        lim_max = `LCJ_RES_MAX;
      end
    end
  endfunction

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  reg  [7:0]  ctrl_q;
  reg  [31:0] lim_q [0:7];
  reg         rej_q;
  reg         ext_s1_q;
  reg         ext_s2_q;
  reg  [31:0] tone_cnt_q;
  reg         phase_q;
  reg  [31:0] once_cnt_q;
  reg         pass_dly_q;
  reg  [31:0] rd_d;
  reg         beep_d;
  integer     i;

  wire        r_over;
  wire        r_pass;
  wire        r_under;
  wire        v_over;
  wire        v_pass;
  wire        v_under;
  wire [31:0] r_rel;
  wire [31:0] v_rel;
  wire [31:0] r_mag;
  wire [31:0] v_mag;

  // ---------------------------------------------
  // outside enable synchroniser
  // ---------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_judge_en;
      ext_s2_q <= ext_s1_q;
    end
  end

  // ---------------------------------------------
  // bus decode
  // ---------------------------------------------
  wire        locked  = ctrl_q[`LCJ_C_EN];
  wire        wr_ev   = avs_write & ~avs_waitrequest;
  wire        is_lim  = (avs_address >= `LCJ_A_LIM0) && (avs_address <= `LCJ_A_LIM7);
  wire [3:0]  idx4    = avs_address[5:2] - 4'h2;
  wire [2:0]  lidx    = idx4[2:0];
  wire [31:0] ctrl_wd = merge({24'h000000, ctrl_q}, avs_writedata, avs_byteenable);
  wire [31:0] lim_wd  = merge(lim_q[lidx], avs_writedata, avs_byteenable);
  wire        ctrl_wr = wr_ev && (avs_address == `LCJ_A_CTRL);
  wire        lim_wr  = wr_ev && is_lim;
  wire        ctrl_bad = locked && (ctrl_wd[7:1] != ctrl_q[7:1]);
  wire        lim_bad  = locked || (lim_wd > lim_max(lidx));
  wire        rej_set  = (ctrl_wr && ctrl_bad) || (lim_wr && lim_bad);
  wire        rej_clr  = wr_ev && (avs_address == `LCJ_A_STAT) &&
                         avs_byteenable[0] && avs_writedata[`LCJ_S_REJ];

  // ---------------------------------------------
  // waitrequest and read data
  // ---------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_d;
      end
    end
  end

  always @* begin
    rd_d = 32'h00000000;
    if (is_lim) begin
      rd_d = lim_q[lidx];
    end else begin
      case (avs_address)
        `LCJ_A_CTRL: rd_d = {24'h000000, ctrl_q};
        `LCJ_A_STAT: rd_d = {25'h0000000, rej_q, v_under, v_pass, v_over,
                             r_under, r_pass, r_over};
        `LCJ_A_RREL: rd_d = r_rel;
        `LCJ_A_VREL: rd_d = v_rel;
        `LCJ_A_RSHOW: rd_d = ctrl_q[`LCJ_C_RTOL] ? r_rel : r_mag;
        `LCJ_A_VSHOW: rd_d = ctrl_q[`LCJ_C_VTOL] ? v_rel : v_mag;
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------
  // configuration registers
  // ---------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q <= `LCJ_CTRL_RST;
      for (i = 0; i < 8; i = i + 1) begin
        lim_q[i] <= `LCJ_LIM_RST;
      end
    end else begin
      if (ctrl_wr && !ctrl_bad) begin
        ctrl_q <= ctrl_wd[7:0];
        if (ctrl_wd[`LCJ_C_EN] && !locked) begin
          ctrl_q[`LCJ_C_ARNG] <= 1'b0;
        end
      end
      if (lim_wr && !lim_bad) begin
        lim_q[lidx] <= lim_wd;
      end
    end
  end

  // set wins over clear
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rej_q <= 1'b0;
    end else if (rej_set) begin
      rej_q <= 1'b1;
    end else if (rej_clr) begin
      rej_q <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      autorange_en_q <= 1'b0;
    end else begin
      autorange_en_q <= ctrl_q[`LCJ_C_ARNG] & ~locked;
    end
  end

  // ---------------------------------------------
  // judging
  // ---------------------------------------------
  wire ext_mode = ctrl_q[`LCJ_C_EXT];
  wire judge_go = meas_valid & locked & (~ext_mode | ext_s2_q);
  wire no_judge = ~locked | (ext_mode & ~ext_s2_q);

  lcj_judge u_res (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .use_tol   (ctrl_q[`LCJ_C_RTOL]),
    .upper_lim (lim_q[0]),
    .lower_lim (lim_q[1]),
    .nominal   (lim_q[2]),
    .tol       (lim_q[3]),
    .judge_go  (judge_go),
    .clr       (no_judge),
    .meas_ok   (res_ok),
    .meas_val  (res_val),
    .over_q    (r_over),
    .pass_q    (r_pass),
    .under_q   (r_under),
    .rel_q     (r_rel),
    .mag_q     (r_mag)
  );

  lcj_judge u_volt (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .use_tol   (ctrl_q[`LCJ_C_VTOL]),
    .upper_lim (lim_q[4]),
    .lower_lim (lim_q[5]),
    .nominal   (lim_q[6]),
    .tol       (lim_q[7]),
    .judge_go  (judge_go),
    .clr       (no_judge),
    .meas_ok   (volt_ok),
    .meas_val  (volt_val),
    .over_q    (v_over),
    .pass_q    (v_pass),
    .under_q   (v_under),
    .rel_q     (v_rel),
    .mag_q     (v_mag)
  );

  assign res_over_max_bound   = r_over;
  assign res_pass             = r_pass;
  assign res_under_min_bound  = r_under;
  assign volt_over_max_bound  = v_over;
  assign volt_pass            = v_pass;
  assign volt_under_min_bound = v_under;

  // ---------------------------------------------
  // outside port verdicts
  // ---------------------------------------------
  wire any_over  = r_over | v_over;
  wire any_under = r_under | v_under;
  wire any_rej   = any_over | any_under;
  wire pass_all  = (r_pass | v_pass) & ~any_rej;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      ext_over_q  <= 1'b0;
      ext_pass_q  <= 1'b0;
      ext_under_q <= 1'b0;
    end else begin
      ext_over_q  <= any_over;
      ext_pass_q  <= pass_all;
      ext_under_q <= any_under;
    end
  end

  // ---------------------------------------------
  // beeper timing
  // ---------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n || !any_rej) begin
      tone_cnt_q <= 32'h00000000;
      phase_q    <= 1'b1;
    end else if (tone_cnt_q >= BEEP_TICKS - 32'h00000001) begin
      tone_cnt_q <= 32'h00000000;
      phase_q    <= ~phase_q;
    end else begin
      tone_cnt_q <= tone_cnt_q + 32'h00000001;
    end
  end

  // single tone on entry into pass
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pass_dly_q <= 1'b0;
      once_cnt_q <= 32'h00000000;
    end else begin
      pass_dly_q <= pass_all;
      if (!pass_all) begin
        once_cnt_q <= 32'h00000000;
      end else if (!pass_dly_q) begin
        once_cnt_q <= ONCE_TICKS;
      end else if (once_cnt_q != 32'h00000000) begin
        once_cnt_q <= once_cnt_q - 32'h00000001;
      end
    end
  end

  // ---------------------------------------------
  // beeper select
  // ---------------------------------------------
  wire rej_tone  = any_rej & phase_q;
  wire once_tone = pass_all & (once_cnt_q != 32'h00000000);

  always @* begin
    case (ctrl_q[`LCJ_C_BHI:`LCJ_C_BLO])
      `LCJ_BP_OFF: beep_d = 1'b0;
      `LCJ_BP_IN:  beep_d = pass_all;
      `LCJ_BP_REJ: beep_d = rej_tone;
      `LCJ_BP_BT1: beep_d = pass_all | rej_tone;
      `LCJ_BP_BT2: beep_d = once_tone | rej_tone;
      default:     beep_d = 1'b0;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      beep_q <= 1'b0;
    end else begin
      beep_q <= beep_d;
    end
  end

endmodule

// >>> verif/lcj_front.sv
// measurement front end and outside control port model
`timescale 1ns/1ns
module lcj_front (
  // clock
  input  logic        core_clk,
  // results
  output logic        meas_valid,
  output logic        res_ok,
  output logic [31:0] res_val,
  output logic        volt_ok,
  output logic [31:0] volt_val,
  // outside control port
  output logic        ext_judge_en
);
  initial begin
    meas_valid   = 1'b0;
    res_ok       = 1'b0;
    volt_ok      = 1'b0;
    res_val      = 32'h0;
    volt_val     = 32'h0;
    ext_judge_en = 1'b0;
  end
  // one-cycle result pulse; values scrambled once it is over
  task automatic send(input [31:0] r, input [31:0] v, input ok);
    @(posedge core_clk);
    meas_valid <= 1'b1;
    res_val    <= r;
    volt_val   <= v;
    res_ok     <= ok;
    volt_ok    <= 1'b1;
    @(posedge core_clk);
    meas_valid <= 1'b0;
    res_val    <= ~r;
    volt_val   <= ~v;
    res_ok     <= ~ok;
    volt_ok    <= 1'b0;
  endtask
  // outside controller decides when judging may happen
  task automatic allow(input en);
    @(posedge core_clk);
    ext_judge_en <= en;
  endtask
endmodule

// >>> verif/lcj_monitor.sv
// assertion checker on the limit judge top ports
`timescale 1ns/1ns
module lcj_monitor (
  // clock and reset
  input logic core_clk,
  input logic rst_n,
  // bus handshake
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  // front end
  input logic meas_valid,
  // verdicts and outputs
  input logic res_over_max_bound,
  input logic res_pass,
  input logic res_under_min_bound,
  input logic volt_over_max_bound,
  input logic volt_pass,
  input logic volt_under_min_bound,
  input logic ext_over_q,
  input logic ext_pass_q,
  input logic ext_under_q,
  input logic beep_q,
  input logic autorange_en_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire r_any = res_over_max_bound | res_pass | res_under_min_bound;
  wire v_any = volt_over_max_bound | volt_pass | volt_under_min_bound;
  wire rej   = res_over_max_bound | res_under_min_bound | volt_over_max_bound |
               volt_under_min_bound;
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property (bus_req |=> one_wait)
    else $error("bus answer not a single cycle");
  wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("bus answer without request");
  res_onehot_a: assert property ($onehot0({res_over_max_bound, res_pass,
    res_under_min_bound})) else $error("resistance verdicts overlap");
  volt_onehot_a: assert property ($onehot0({volt_over_max_bound, volt_pass,
    volt_under_min_bound})) else $error("voltage verdicts overlap");
  ext_over_a: assert property (ext_over_q == $past(res_over_max_bound | volt_over_max_bound))
    else $error("outside over output wrong");
  ext_under_a: assert property (ext_under_q == $past(res_under_min_bound |
    volt_under_min_bound)) else $error("outside under output wrong");
  ext_pass_a: assert property (ext_pass_q == $past((res_pass | volt_pass) & !rej))
    else $error("outside pass output wrong");
  verdict_hold_a: assert property (!$past(meas_valid) && (r_any || v_any) |->
    $stable({r_any, v_any, rej, res_pass, volt_pass})) else $error("verdict moved unjudged");
  beep_cause_a: assert property (beep_q |-> $past(r_any | v_any))
    else $error("beeper on without verdict");
  auto_off_a: assert property ($rose(r_any) |-> !autorange_en_q)
    else $error("auto range on while judging");
endmodule

// >>> verif/tb_limit_comparator_judge.sv
// self-checking bench of the limit comparator judge
`timescale 1ns/1ns
`include "lcj_regs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t got %0h expected %0h", $time, (g), (e)); end end
module tb_limit_comparator_judge;
  logic        core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, ctrl_v;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, res_val, volt_val, d;
  logic        meas_valid, res_ok, volt_ok, ext_judge_en;
  logic        ext_over_q, ext_pass_q, ext_under_q, beep_q, autorange_en_q;
  logic        r_ov, r_ps, r_un, v_ov, v_ps, v_un;
  int          n_fail, num_checks, cycles;
  lcj_top #(.BEEP_TICKS(32'h4), .ONCE_TICKS(32'h6)) u_dut (.core_clk(core_clk),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .meas_valid(meas_valid), .res_ok(res_ok), .res_val(res_val), .volt_ok(volt_ok),
    .volt_val(volt_val), .ext_judge_en(ext_judge_en), .ext_over_q(ext_over_q),
    .ext_pass_q(ext_pass_q), .ext_under_q(ext_under_q), .res_over_max_bound(r_ov),
    .res_pass(r_ps), .res_under_min_bound(r_un), .volt_over_max_bound(v_ov),
    .volt_pass(v_ps), .volt_under_min_bound(v_un), .beep_q(beep_q),
    .autorange_en_q(autorange_en_q));
  lcj_front u_fe (.core_clk(core_clk), .meas_valid(meas_valid), .res_ok(res_ok),
    .res_val(res_val), .volt_ok(volt_ok), .volt_val(volt_val), .ext_judge_en(ext_judge_en));
  // -----------------------------------
  // bus access and closing
  // -----------------------------------
  task automatic bus(input logic w, input [7:0] a, input [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rchk(input [7:0] a, input [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(d, e)
  endtask
  // clear enable first so the other bits may change
  task automatic set_ctrl(input [7:0] v);
    bus(1'b1, `LCJ_A_CTRL, {24'h0, ctrl_v & 8'hFE});
    bus(1'b1, `LCJ_A_CTRL, {24'h0, v & 8'hFE});
    bus(1'b1, `LCJ_A_CTRL, {24'h0, v});
    ctrl_v = v;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // -----------------------------------
  // scenarios
  // -----------------------------------
  task automatic t_reset;
    rchk(`LCJ_A_CTRL, 32'h0);
    rchk(`LCJ_A_STAT, 32'h0);
    rchk(8'h14, 32'h0);
    bus(1'b1, 8'h40, 32'hFFFF);
    rchk(8'h40, 32'h0);
  endtask
  task automatic t_direct;
    logic [31:0] rv[6] = '{32'd1001, 32'd1000, 32'hFFFFFD44, 32'd500, 32'd499, 32'd1000};
    logic [31:0] vv[6] = '{32'd1000, 32'd2001, 32'd2000, 32'd99, 32'hFFFFFF9C, 32'd1000};
    logic [5:0]  es[6] = '{6'h11, 6'h0A, 6'h12, 6'h22, 6'h14, 6'h10};
    bus(1'b1, 8'h08, 32'd1000);
    bus(1'b1, 8'h0C, 32'd500);
    bus(1'b1, 8'h18, 32'd2000);
    bus(1'b1, 8'h1C, 32'd100);
    set_ctrl(8'h05);
    for (int i = 0; i < 6; i++) begin
      u_fe.send(rv[i], vv[i], i != 5);
      @(posedge core_clk);
      `CHK({r_un, r_ps, r_ov}, es[i][2:0])
      rchk(`LCJ_A_STAT, {26'h0, es[i]});
    end
  endtask
  task automatic t_lock;
    bus(1'b1, 8'h08, 32'd5);
    rchk(8'h08, 32'd1000);
    bus(1'b1, `LCJ_A_CTRL, 32'h07);
    rchk(`LCJ_A_CTRL, 32'h05);
    bus(1'b0, `LCJ_A_STAT, 32'h0);
    `CHK(d[6], 1'b1)
    bus(1'b1, `LCJ_A_STAT, 32'h40);
    bus(1'b0, `LCJ_A_STAT, 32'h0);
    `CHK(d[6], 1'b0)
  endtask
  task automatic t_range;
    set_ctrl(8'h00);
    bus(1'b1, 8'h08, 32'h186A0);
    rchk(8'h08, 32'd1000);
    bus(1'b1, 8'h08, 32'h1869F);
    rchk(8'h08, 32'h1869F);
    avs_byteenable <= 4'h1;
    bus(1'b1, 8'h08, 32'hFFFFFF05);
    avs_byteenable <= 4'hF;
    rchk(8'h08, 32'h00018605);
    bus(1'b1, 8'h18, 32'hF4240);
    rchk(8'h18, 32'd2000);
    bus(1'b1, 8'h14, 32'h186A0);
    bus(1'b0, `LCJ_A_STAT, 32'h0);
    `CHK(d[6], 1'b1)
    bus(1'b1, `LCJ_A_STAT, 32'h40);
  endtask
  task automatic t_tol;
    bus(1'b1, 8'h10, 32'd1000);
    bus(1'b1, 8'h14, 32'd10000);
    bus(1'b1, 8'h20, 32'd2000);
    bus(1'b1, 8'h24, 32'd5000);
    set_ctrl(8'h61);
    u_fe.send(32'd1100, 32'd1950, 1'b1);
    rchk(`LCJ_A_STAT, 32'h12);
    rchk(`LCJ_A_RREL, 32'h2710);
    rchk(`LCJ_A_VSHOW, 32'hFFFFF63C);
    u_fe.send(32'd1101, 32'd2101, 1'b1);
    rchk(`LCJ_A_STAT, 32'h09);
    u_fe.send(32'd899, 32'd1899, 1'b1);
    rchk(`LCJ_A_STAT, 32'h24);
    rchk(`LCJ_A_RREL, 32'hFFFFD88C);
  endtask
  task automatic t_manual;
    set_ctrl(8'h03);
    u_fe.send(32'd1000, 32'd1000, 1'b1);
    rchk(`LCJ_A_STAT, 32'h0);
    u_fe.allow(1'b1);
    repeat (4) @(posedge core_clk);
    u_fe.send(32'd1000, 32'd1000, 1'b1);
    rchk(`LCJ_A_STAT, 32'h12);
    u_fe.allow(1'b0);
  endtask
  task automatic beep_chk(input [2:0] m, input [31:0] r, input int lo, input int hi);
    int c;
    set_ctrl({3'h0, m, 2'h1});
    u_fe.send(32'd50, 32'd1000, 1'b1);
    u_fe.send(r, 32'd1000, 1'b1);
    c = 0;
    repeat (20) begin
      @(posedge core_clk);
      c += (beep_q === 1'b1);
    end
    `CHK(c >= lo && c <= hi, 1'b1)
  endtask
  task automatic t_beep;
    beep_chk(`LCJ_BP_OFF, 32'd50, 0, 0);
    beep_chk(`LCJ_BP_IN, 32'd1000, 17, 20);
    beep_chk(`LCJ_BP_REJ, 32'd50, 5, 15);
    beep_chk(`LCJ_BP_REJ, 32'd1000, 0, 3);
    beep_chk(`LCJ_BP_BT1, 32'd1000, 17, 20);
    beep_chk(`LCJ_BP_BT1, 32'd50, 5, 15);
    beep_chk(`LCJ_BP_BT2, 32'd1000, 1, 10);
  endtask
  task automatic t_auto;
    set_ctrl(8'h80);
    repeat (2) @(posedge core_clk);
    `CHK(autorange_en_q, 1'b1)
    set_ctrl(8'h81);
    repeat (2) @(posedge core_clk);
    `CHK(autorange_en_q, 1'b0)
    rchk(`LCJ_A_CTRL, 32'h01);
  endtask
  // -----------------------------------
  // clock, watchdog and main sequence
  // -----------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    ctrl_v = 8'h0;
    n_fail = 0;
    num_checks = 0;
    cycles = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_direct();
    t_lock();
    t_range();
    t_tol();
    t_manual();
    t_beep();
    t_auto();
    summarize();
  end
endmodule
bind lcj_top lcj_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .meas_valid(meas_valid),
  .res_over_max_bound(res_over_max_bound), .res_pass(res_pass),
  .res_under_min_bound(res_under_min_bound), .volt_over_max_bound(volt_over_max_bound),
  .volt_pass(volt_pass), .volt_under_min_bound(volt_under_min_bound),
  .ext_over_q(ext_over_q), .ext_pass_q(ext_pass_q), .ext_under_q(ext_under_q),
  .beep_q(beep_q), .autorange_en_q(autorange_en_q));
